// file: hdl/cms_defines.svh
`ifndef CMS_DEFINES_SVH
`define CMS_DEFINES_SVH

// ==========================================================
// register byte offsets
`define CMS_OFF_MODE      8'h00
`define CMS_OFF_MISC      8'h04
`define CMS_OFF_STATUS    8'h08
`define CMS_OFF_SECURITY  8'h0C
`define CMS_OFF_POWER     8'h10

// ==========================================================
// field positions
`define CMS_MISC_FLASH_EN   0
`define CMS_ST_SECURE       0
`define CMS_ST_ERASED       1
`define CMS_ST_VERIFYING    2
`define CMS_ST_VERIFIED     3
`define CMS_ST_DBG_ACTIVE   4
`define CMS_ST_DBG_BLOCKED  5
`define CMS_ST_LP_LSB       8
`define CMS_SEC_UNSECURE    0
`define CMS_POW_CMD_LSB     0

// ==========================================================
// reset values and timing
`define CMS_VERIFY_CYCLES   16
`define CMS_RD_ZERO         32'h0000_0000

`endif

// file: hdl/cms_pkg.sv
package cms_pkg;

  // strap code, ordered {mode_strap_2, mode_strap_1, mode_strap_0}
  typedef enum logic [2:0] {
    CMS_SPECIAL_SINGLE   = 3'b000,
    CMS_EMUL_NARROW      = 3'b001,
    CMS_SPECIAL_TEST     = 3'b010,
    CMS_EMUL_WIDE        = 3'b011,
    CMS_NORMAL_SINGLE    = 3'b100,
    CMS_NORMAL_NARROW    = 3'b101,
    CMS_PERIPHERAL       = 3'b110,
    CMS_NORMAL_WIDE      = 3'b111
  } cms_mode_e;

  typedef enum logic [1:0] {
    CMS_LP_RUN    = 2'b00,
    CMS_LP_WAIT   = 2'b01,
    CMS_LP_STOP   = 2'b10,
    CMS_LP_PSTOP  = 2'b11
  } cms_lp_e;

  // clock gating outputs travel together
  typedef struct packed {
    logic osc_en;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic rti_cop_clk_en;
    logic cpu_bus_hold;
  } cms_clk_s;

  typedef struct packed {
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic       vis_s1;
    logic       vis_s2;
    logic       xirq_s1;
    logic       xirq_s2;
    cms_mode_e  mode;
    logic       flash_en;
    logic       secure;
    logic       erased;
    logic [7:0] verify_cnt;
    logic       verified;
    logic       dbg_cmd_seen;
    logic       dbg_active;
    cms_lp_e    lp;
    cms_clk_s   clk;
    logic       unsec_req;
    logic       ack;
    logic [31:0] dat;
  } cms_state_s;

endpackage

// file: hdl/cms_ctl.sv
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "cms_defines.svh"
module cms_ctl #(
  parameter int VERIFY_CYCLES = `CMS_VERIFY_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_mode_strap_2,
  input  wire logic        i_mode_strap_1,
  input  wire logic        i_mode_strap_0,
  input  wire logic        i_flash_visibility_strap,
  input  wire logic        i_flash_secure,
  input  wire logic        i_flash_erased,
  input  wire logic        i_debug_activate_cmd,
  input  wire logic        i_ext_irq,
  input  wire logic        i_irq,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  output logic [2:0]       o_mode,
  output logic             o_flash_visible,
  output logic             o_secure,
  output logic             o_debug_active,
  output logic             o_unsecure_req,
  output cms_pkg::cms_clk_s o_clk_ctl
);

  // ==========================================================
  // state
  cms_pkg::cms_state_s state_reg;
  cms_pkg::cms_state_s state_next;
  logic                wr_en;
  logic                rd_en;
  logic                expanded;
  logic                dbg_blocked;
  logic [2:0]          wmode;
  logic                wr_ok;
  logic                wake;
  logic [31:0]         status_word;

  // ==========================================================
  // strap decode of the flash enable bit
  function automatic logic flash_from_strap(input logic [2:0] m, input logic vis);
    logic r;
    r = 1'b0;
    unique case (cms_pkg::cms_mode_e'(m))
      cms_pkg::CMS_SPECIAL_SINGLE: r = 1'b1;
      cms_pkg::CMS_EMUL_NARROW:    r = ~vis;
      cms_pkg::CMS_SPECIAL_TEST:   r = 1'b0;
      cms_pkg::CMS_EMUL_WIDE:      r = ~vis;
      cms_pkg::CMS_NORMAL_SINGLE:  r = 1'b1;
      cms_pkg::CMS_NORMAL_NARROW:  r = vis;
      cms_pkg::CMS_PERIPHERAL:     r = 1'b1;
      cms_pkg::CMS_NORMAL_WIDE:    r = vis;
    endcase
    return r;
  endfunction

  // special modes may go anywhere legal; normal modes only between normal
  // expanded targets, so a field part cannot fall back into a test mode
  function automatic logic mode_write_ok(input logic [2:0] from, input logic [2:0] to);
    logic r;
    r = 1'b0;
    if (to == 3'h6)
    begin
      r = 1'b0;
    end
    else if (from[2] == 1'b0)
    begin
      r = 1'b1;
    end
    else
    begin
      r = (to == 3'h5) || (to == 3'h7) || (to == from);
    end
    return r;
  endfunction

  assign expanded    = (state_reg.mode != cms_pkg::CMS_SPECIAL_SINGLE) &&
                       (state_reg.mode != cms_pkg::CMS_NORMAL_SINGLE);
  // debug stays blocked on a secured part until erase verify has passed
  assign dbg_blocked = state_reg.secure & ~state_reg.verified;
  assign wr_en       = i_wb_cyc & i_wb_stb & i_wb_we & ~state_reg.ack;
  assign rd_en       = i_wb_cyc & i_wb_stb & ~i_wb_we & ~state_reg.ack;
  assign wmode       = i_wb_dat[2:0];
  assign wr_ok       = i_wb_sel[0] & mode_write_ok(state_reg.mode, wmode);
  assign wake        = state_reg.xirq_s2 | i_irq;

  always_comb
  begin
    status_word = `CMS_RD_ZERO;
    status_word[`CMS_ST_SECURE]     = state_reg.secure;
    status_word[`CMS_ST_ERASED]     = state_reg.erased;
    status_word[`CMS_ST_VERIFYING]  = state_reg.verify_cnt != 8'h00;
    status_word[`CMS_ST_VERIFIED]   = state_reg.verified;
    status_word[`CMS_ST_DBG_ACTIVE] = state_reg.dbg_active;
    status_word[`CMS_ST_DBG_BLOCKED] = dbg_blocked;
    status_word[`CMS_ST_LP_LSB +: 2] = state_reg.lp;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    state_next = state_reg;
    state_next.strap_s1 = {i_mode_strap_2, i_mode_strap_1, i_mode_strap_0};
    state_next.strap_s2 = state_reg.strap_s1;
    state_next.vis_s1   = i_flash_visibility_strap;
    state_next.vis_s2   = state_reg.vis_s1;
    state_next.xirq_s1  = i_ext_irq;
    state_next.xirq_s2  = state_reg.xirq_s1;
    state_next.ack       = 1'b0;
    state_next.unsec_req = 1'b0;
    if (!i_rst_n)
    begin
      // sampled every reset cycle, so the last one before release wins
      state_next.mode     = cms_pkg::cms_mode_e'(state_reg.strap_s2);
      // a secured part reset straight into an expanded mode comes up with flash hidden
      state_next.flash_en = flash_from_strap(state_reg.strap_s2, state_reg.vis_s2) &
                            !(i_flash_secure && state_reg.strap_s2 != 3'h0 &&
                              state_reg.strap_s2 != 3'h4);
      state_next.secure   = i_flash_secure;
      state_next.erased   = i_flash_erased;
      state_next.verified = 1'b0;
      state_next.verify_cnt = 8'h00;
      if (i_flash_secure && i_flash_erased && state_reg.strap_s2 == 3'h0)
      begin
        state_next.verify_cnt = 8'(VERIFY_CYCLES);
      end
      state_next.dbg_cmd_seen = 1'b0;
      state_next.dbg_active   = 1'b0;
      state_next.lp  = cms_pkg::CMS_LP_RUN;
      state_next.clk = '{osc_en: 1'b1, cpu_clk_en: 1'b1, periph_clk_en: 1'b1,
                         rti_cop_clk_en: 1'b1, cpu_bus_hold: 1'b0};
      state_next.dat = `CMS_RD_ZERO;
    end
    else
    begin
      // erase verify countdown
      if (state_reg.verify_cnt != 8'h00)
      begin
        state_next.verify_cnt = state_reg.verify_cnt - 8'h01;
        if (state_reg.verify_cnt == 8'h01)
        begin
          state_next.verified = 1'b1;
        end
      end
      // debug activation; the command is sticky and set wins over nothing
      if (i_debug_activate_cmd)
      begin
        state_next.dbg_cmd_seen = 1'b1;
      end
      state_next.dbg_active = ~dbg_blocked &
        ((state_reg.mode == cms_pkg::CMS_SPECIAL_SINGLE) | state_reg.dbg_cmd_seen);
      // secured expanded operation never sees the internal flash
      if (state_reg.secure && expanded)
      begin
        state_next.flash_en = 1'b0;
      end
      // register access
      if (wr_en || rd_en)
      begin
        state_next.ack = 1'b1;
      end
      if (rd_en)
      begin
        unique case (i_wb_adr)
          `CMS_OFF_MODE:     state_next.dat = {29'h0, state_reg.mode};
          `CMS_OFF_MISC:     state_next.dat = {31'h0, state_reg.flash_en};
          `CMS_OFF_STATUS:   state_next.dat = status_word;
          `CMS_OFF_SECURITY: state_next.dat = `CMS_RD_ZERO;
          `CMS_OFF_POWER:    state_next.dat = {30'h0, state_reg.lp};
          default:           state_next.dat = `CMS_RD_ZERO;
        endcase
      end
      if (wr_en && i_wb_adr == `CMS_OFF_MODE && wr_ok)
      begin
        state_next.mode = cms_pkg::cms_mode_e'(wmode);
        if (state_reg.secure && wmode != 3'h0 && wmode != 3'h4)
        begin
          state_next.flash_en = 1'b0;
        end
      end
      if (wr_en && i_wb_adr == `CMS_OFF_SECURITY && i_wb_sel[0] &&
          i_wb_dat[`CMS_SEC_UNSECURE] && (state_reg.verified || !state_reg.secure))
      begin
        state_next.unsec_req = 1'b1;
      end
      // low power sequencing
      unique case (state_reg.lp)
        cms_pkg::CMS_LP_RUN:
        begin
          if (wr_en && i_wb_adr == `CMS_OFF_POWER && i_wb_sel[0])
          begin
            state_next.lp = cms_pkg::cms_lp_e'(i_wb_dat[`CMS_POW_CMD_LSB +: 2]);
          end
        end
        cms_pkg::CMS_LP_WAIT:
        begin
          if (wake)
          begin
            state_next.lp = cms_pkg::CMS_LP_RUN;
          end
        end
        cms_pkg::CMS_LP_STOP:
        begin
          // with the oscillator off only the pin interrupt can restart it
          if (state_reg.xirq_s2)
          begin
            state_next.lp = cms_pkg::CMS_LP_RUN;
          end
        end
        cms_pkg::CMS_LP_PSTOP:
        begin
          if (wake)
          begin
            state_next.lp = cms_pkg::CMS_LP_RUN;
          end
        end
      endcase
      unique case (state_next.lp)
        cms_pkg::CMS_LP_RUN:
          state_next.clk = '{osc_en: 1'b1, cpu_clk_en: 1'b1, periph_clk_en: 1'b1,
                             rti_cop_clk_en: 1'b1, cpu_bus_hold: 1'b0};
        cms_pkg::CMS_LP_WAIT:
          state_next.clk = '{osc_en: 1'b1, cpu_clk_en: 1'b0, periph_clk_en: 1'b1,
                             rti_cop_clk_en: 1'b1, cpu_bus_hold: 1'b1};
        cms_pkg::CMS_LP_STOP:
          state_next.clk = '{osc_en: 1'b0, cpu_clk_en: 1'b0, periph_clk_en: 1'b0,
                             rti_cop_clk_en: 1'b0, cpu_bus_hold: 1'b1};
        cms_pkg::CMS_LP_PSTOP:
          state_next.clk = '{osc_en: 1'b1, cpu_clk_en: 1'b0, periph_clk_en: 1'b0,
                             rti_cop_clk_en: 1'b1, cpu_bus_hold: 1'b1};
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    state_reg <= state_next;
  end

  // ==========================================================
  // outputs
  assign o_wb_dat        = state_reg.dat;
  assign o_wb_ack        = state_reg.ack;
  assign o_mode          = state_reg.mode;
  assign o_flash_visible = state_reg.flash_en;
  assign o_secure        = state_reg.secure;
  assign o_debug_active  = state_reg.dbg_active;
  assign o_unsecure_req  = state_reg.unsec_req;
  assign o_clk_ctl       = state_reg.clk;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_released;
    $rose(i_rst_n);
  endsequence

  a_mode_latch: assert property (s_released |-> o_mode == $past(state_reg.strap_s2))
    else $error("mode not latched from straps at reset release");
  a_flash_latch: assert property (s_released |-> o_flash_visible ==
    ($past(i_flash_secure) && o_mode != 3'h0 && o_mode != 3'h4 ? 1'b0 :
     flash_from_strap($past(state_reg.strap_s2), $past(state_reg.vis_s2))))
    else $error("flash enable not latched from strap");
  a_ssc_debug: assert property (s_released ##1 (o_mode == 3'h0 && !dbg_blocked)
    |=> o_debug_active)
    else $error("debug not active in special single chip");
  a_dbg_blocked: assert property (dbg_blocked |=> !o_debug_active)
    else $error("debug active while secured");
  a_sec_expanded: assert property (o_secure && expanded |=> !o_flash_visible)
    else $error("flash visible on secured expanded part");
  a_mode_hold: assert property (!(wr_en && i_wb_adr == `CMS_OFF_MODE)
    |=> $stable(o_mode))
    else $error("mode changed without a write");
  a_bad_write: assert property (wr_en && i_wb_adr == `CMS_OFF_MODE && !wr_ok
    |=> $stable(o_mode))
    else $error("forbidden mode transition taken");
  a_verify_len: assert property (s_released ##0 state_reg.verify_cnt != 8'h00
    |-> !state_reg.verified ##VERIFY_CYCLES state_reg.verified)
    else $error("erase verify length wrong");
  a_stop_clk: assert property (o_clk_ctl.osc_en == 1'b0 |->
    !o_clk_ctl.periph_clk_en && !o_clk_ctl.cpu_clk_en)
    else $error("clock running in full stop");
  a_pstop_clk: assert property (state_reg.lp == cms_pkg::CMS_LP_PSTOP |->
    o_clk_ctl.osc_en && o_clk_ctl.rti_cop_clk_en && !o_clk_ctl.periph_clk_en)
    else $error("pseudo stop gating wrong");
  a_wait_clk: assert property (state_reg.lp == cms_pkg::CMS_LP_WAIT |->
    o_clk_ctl.periph_clk_en && o_clk_ctl.cpu_bus_hold && !o_clk_ctl.cpu_clk_en)
    else $error("wait gating wrong");
  a_bus_ack: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack not one cycle");

  // security state, debug gating and mode readback between resets
  a_unsec_gate: assert property (o_unsecure_req |->
    $past(state_reg.verified) || !$past(state_reg.secure))
    else $error("unsecure request before erase verify");
  a_secure_hold: assert property (i_rst_n |=> $stable(o_secure))
    else $error("security changed outside reset");
  a_dbg_wait: assert property (!state_reg.dbg_cmd_seen &&
    state_reg.mode != cms_pkg::CMS_SPECIAL_SINGLE |=> !o_debug_active)
    else $error("debug active without a command");
  a_mode_readback: assert property (rd_en && i_wb_adr == `CMS_OFF_MODE
    |=> o_wb_dat[2:0] == $past(o_mode))
    else $error("mode read back wrong");

  // low power exits: full stop only leaves on the synchronised pin
  a_stop_hold: assert property (state_reg.lp == cms_pkg::CMS_LP_STOP &&
    !state_reg.xirq_s2 |=> state_reg.lp == cms_pkg::CMS_LP_STOP)
    else $error("full stop left without pin interrupt");
  a_lp_wake: assert property ((state_reg.lp == cms_pkg::CMS_LP_WAIT ||
    state_reg.lp == cms_pkg::CMS_LP_PSTOP) && wake |=> o_clk_ctl.cpu_clk_en)
    else $error("wait or pseudo stop not left on wake");

endmodule

// file: verification/cms_board_model.sv
`timescale 1ns/1ps
// ==========================================================
// board straps and reset line
// straps are plain board levels; a reset request from the bench pulls the
// reset line low for RST_CYCLES edges, long enough for the strap synchroniser
module cms_board_model #(
  parameter int RST_CYCLES = 5
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_req,
  input  wire logic [2:0] i_code,
  input  wire logic       i_vis,
  output logic            o_mode_strap_2,
  output logic            o_mode_strap_1,
  output logic            o_mode_strap_0,
  output logic            o_flash_visibility_strap,
  output logic            o_rst_n
);
  logic [2:0] strap_reg = 3'h4;
  int         hold_cnt  = 3;

  always_ff @(posedge i_clk)
  begin
    // a board never straps the peripheral code: keep the last legal one
    if (i_code != 3'h6) strap_reg <= i_code;
    if (i_rst_req) hold_cnt <= RST_CYCLES;
    else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
  end

  assign o_mode_strap_2           = strap_reg[2];
  assign o_mode_strap_1           = strap_reg[1];
  assign o_mode_strap_0           = strap_reg[0];
  assign o_flash_visibility_strap = i_vis;
  assign o_rst_n                  = (hold_cnt == 0);
endmodule

// file: verification/cms_ctl_bench.sv
`timescale 1ns/1ps
`include "cms_defines.svh"
module cms_ctl_bench;
  // ==========================================================
  // signals
  logic              clk;
  logic              rst_n;
  logic              strap_2, strap_1, strap_0, vis_strap;
  logic [2:0]        code;
  logic              vis, rst_req, fl_secure, fl_erased, dbg_cmd, ext_irq, irq;
  logic              cyc, stb, we, ack;
  logic [7:0]        adr;
  logic [3:0]        sel;
  logic [31:0]       wdat, rdat, q;
  logic [2:0]        mode;
  logic              fl_vis, secure, dbg_act, unsec_req;
  cms_pkg::cms_clk_s clk_ctl;
  int                fails, num_checks, cycles, unsec_seen;
  localparam logic [2:0] WTO [4] = '{3'h0, 3'h6, 3'h5, 3'h7};
  localparam logic [2:0] WEXP [4] = '{3'h4, 3'h4, 3'h5, 3'h7};
  localparam logic [1:0] PCMD [3] = '{2'h1, 2'h3, 2'h2};
  localparam logic [3:0] PEXP [3] = '{4'hB, 4'h9, 4'h0};

  cms_board_model u_board (.i_clk(clk), .i_rst_req(rst_req), .i_code(code), .i_vis(vis),
    .o_mode_strap_2(strap_2), .o_mode_strap_1(strap_1), .o_mode_strap_0(strap_0),
    .o_flash_visibility_strap(vis_strap), .o_rst_n(rst_n));

  cms_ctl #(.VERIFY_CYCLES(2)) u_dut (.i_clk(clk), .i_rst_n(rst_n),
    .i_mode_strap_2(strap_2), .i_mode_strap_1(strap_1), .i_mode_strap_0(strap_0),
    .i_flash_visibility_strap(vis_strap), .i_flash_secure(fl_secure),
    .i_flash_erased(fl_erased), .i_debug_activate_cmd(dbg_cmd), .i_ext_irq(ext_irq),
    .i_irq(irq), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_mode(mode),
    .o_flash_visible(fl_vis), .o_secure(secure), .o_debug_active(dbg_act),
    .o_unsecure_req(unsec_req), .o_clk_ctl(clk_ctl));

  // ==========================================================
  // clock, timeout and pulse monitor
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (unsec_req === 1'b1) unsec_seen++;
    // the whole run needs well under a thousand cycles
    if (cycles == 5000)
    begin
      fails++;
      test_done();
    end
  end

  // ==========================================================
  // helpers
  function automatic logic fexp(input logic [2:0] c, input logic v);
    case (c)
      3'h1, 3'h3: return ~v;
      3'h2:       return 1'b0;
      3'h5, 3'h7: return v;
      default:    return 1'b1;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic reset_to(input logic [2:0] c, input logic v, input logic s, input logic e);
    @(posedge clk);
    code      <= c;
    vis       <= v;
    fl_secure <= s;
    fl_erased <= e;
    rst_req   <= 1'b1;
    @(posedge clk);
    rst_req <= 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic pulse_dbg();
    @(posedge clk);
    dbg_cmd <= 1'b1;
    @(posedge clk);
    dbg_cmd <= 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial
  begin
    code = 3'h4; vis = 1'b0; rst_req = 1'b0; fl_secure = 1'b0; fl_erased = 1'b0;
    dbg_cmd = 1'b0; ext_irq = 1'b0; irq = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; sel = 4'hF; wdat = 32'h0000_0000;
    fails = 0; num_checks = 0; cycles = 0; unsec_seen = 0;
    repeat (6) @(posedge clk);

    for (int i = 0; i < 16; i++)
    begin
      if (i[3:1] != 3'h6)
      begin
        reset_to(i[3:1], i[0], 1'b0, 1'b0);
        chk(mode, i[3:1]);
        chk(fl_vis, fexp(i[3:1], i[0]));
        chk(dbg_act, i[3:1] == 3'h0);
        wb_xfer(1'b0, `CMS_OFF_MISC, 32'h0);
        chk(q[0], fexp(i[3:1], i[0]));
      end
    end
    @(posedge clk);
    code <= 3'h0;
    vis  <= 1'b0;
    repeat (5) @(negedge clk);
    chk(mode, 3'h7);
    chk(fl_vis, 1'b1);
    $display("test strap decode done");

    reset_to(3'h4, 1'b0, 1'b0, 1'b0);
    pulse_dbg();
    chk(dbg_act, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      wb_xfer(1'b1, `CMS_OFF_MODE, {29'h0, WTO[k]});
      wb_xfer(1'b0, `CMS_OFF_MODE, 32'h0);
      chk(q[2:0], WEXP[k]);
      chk(mode, WEXP[k]);
    end
    reset_to(3'h0, 1'b0, 1'b0, 1'b0);
    wb_xfer(1'b1, `CMS_OFF_MODE, 32'h6);
    chk(mode, 3'h0);
    wb_xfer(1'b1, `CMS_OFF_MODE, 32'h7);
    chk(mode, 3'h7);
    wb_xfer(1'b1, 8'hFC, 32'h4);
    wb_xfer(1'b0, 8'hFC, 32'h0);
    chk(q, 32'h0);
    chk(mode, 3'h7);
    $display("test mode writes done");

    reset_to(3'h4, 1'b0, 1'b1, 1'b0);
    chk(secure, 1'b1);
    chk(fl_vis, 1'b1);
    pulse_dbg();
    chk(dbg_act, 1'b0);
    wb_xfer(1'b1, `CMS_OFF_MODE, 32'h5);
    @(negedge clk);
    chk(fl_vis, 1'b0);
    reset_to(3'h7, 1'b1, 1'b1, 1'b0);
    chk(fl_vis, 1'b0);
    pulse_dbg();
    chk(dbg_act, 1'b0);
    reset_to(3'h0, 1'b0, 1'b1, 1'b0);
    wb_xfer(1'b0, `CMS_OFF_STATUS, 32'h0);
    chk(q[3], 1'b0);
    chk(dbg_act, 1'b0);
    wb_xfer(1'b1, `CMS_OFF_SECURITY, 32'h1);
    @(negedge clk);
    chk(unsec_seen, 0);
    reset_to(3'h0, 1'b0, 1'b1, 1'b1);
    wb_xfer(1'b0, `CMS_OFF_STATUS, 32'h0);
    chk(q[3], 1'b1);
    chk(dbg_act, 1'b1);
    wb_xfer(1'b1, `CMS_OFF_SECURITY, 32'h1);
    @(negedge clk);
    chk(unsec_seen, 1);
    reset_to(3'h0, 1'b0, 1'b1, 1'b0);
    chk(secure, 1'b1);
    $display("test security done");

    reset_to(3'h4, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      wb_xfer(1'b1, `CMS_OFF_POWER, {30'h0, PCMD[k]});
      @(negedge clk);
      chk({clk_ctl.osc_en, clk_ctl.cpu_clk_en, clk_ctl.periph_clk_en,
           clk_ctl.rti_cop_clk_en}, PEXP[k]);
      if (k == 0) chk(clk_ctl.cpu_bus_hold, 1'b1);
      @(posedge clk);
      irq <= 1'b1;
      repeat (6) @(negedge clk);
      chk(clk_ctl.cpu_clk_en, k != 2);
      @(posedge clk);
      ext_irq <= 1'b1;
      repeat (6) @(negedge clk);
      chk(clk_ctl.cpu_clk_en, 1'b1);
      chk(clk_ctl.osc_en, 1'b1);
      @(posedge clk);
      irq     <= 1'b0;
      ext_irq <= 1'b0;
      repeat (4) @(posedge clk);
    end
    $display("test low power done");
    test_done();
  end
endmodule
